/* rtl/input_sync.sv */
// Two-stage synchroniser for a vector of external inputs
`timescale 1ns/10ps

module input_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] stable_q;
    logic [W-1:0] stable_d;

    // Next values of both stages
    always_comb begin
        meta_d = async_in;
        stable_d = meta_q;
    end

    // First stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_q <= RST_VAL;
            stable_q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            stable_q <= stable_d;
        end
    end

    assign sync_out = stable_q;

endmodule

/* rtl/motor_driver_io_logic.sv */
// Discrete input decoding and output generation of a brushless motor driver
`timescale 1ns/10ps
`include "motor_io_map.svh"

module motor_driver_io_logic #(
    parameter int TERM_N = 2,
    parameter int SPEED_W = 12,
    parameter int PULSE_CYCLES = `MIO_PULSE_CYCLES,
    parameter int BLINK_CYCLES = `MIO_BLINK_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    // Host operation inputs
    input wire logic cw_run_cmd,
    input wire logic ccw_run_cmd,
    input wire logic stop_style_sel,
    input wire logic start_hold_in,
    input wire logic run_enable_in,
    input wire logic direction_select,
    input wire logic data_sel_bit0,
    input wire logic data_sel_bit1,
    input wire logic data_sel_bit2,
    input wire logic data_sel_bit3,
    input wire logic fault_clear_in,
    input wire logic notice_clear_in,
    input wire logic [TERM_N-1:0] torque_limit_en_in,
    input wire logic [TERM_N-1:0] panel_lock_release,
    input wire logic [TERM_N-1:0] external_stop_in,
    // Terminal assignment and settings
    input wire logic three_wire_mode,
    input wire logic [3:0] data_sel_assigned,
    input wire logic [TERM_N-1:0] torque_limit_assigned,
    input wire logic [TERM_N-1:0] panel_lock_assigned,
    input wire logic [TERM_N-1:0] external_stop_assigned,
    input wire logic [2:0] out_a_func,
    input wire logic [2:0] out_b_func,
    input wire logic out_a_invert,
    input wire logic out_b_invert,
    input wire logic notice_auto_clear,
    input wire logic positive_is_cw,
    input wire logic [8:0] va_width,
    // Motor control loop status
    input wire logic shaft_tick,
    input wire logic motor_turning,
    input wire logic motor_turning_cw,
    input wire logic [SPEED_W-1:0] speed_actual,
    input wire logic [SPEED_W-1:0] speed_target,
    input wire logic torque_at_limit,
    input wire logic notice_cause,
    input wire logic overcurrent_trip,
    input wire logic nvm_error_trip,
    input wire logic protect_trip,
    // Commands to the motor control loop
    output logic run_cmd,
    output logic dir_cw_cmd,
    output logic decel_stop_cmd,
    output logic instant_stop_cmd,
    output logic coast_cmd,
    output logic [3:0] data_sel_num,
    output logic torque_limit_on,
    output logic panel_unlocked,
    // Status and terminals
    output logic fault_out_n,
    output logic alarm_led,
    output logic [3:0] alarm_code,
    output logic motion_out,
    output logic notice_flag_out,
    output logic torque_limited_flag,
    output logic speed_reached_flag,
    output logic rotation_sense_out,
    output logic speed_pulse_out,
    output logic output_terminal_a,
    output logic output_terminal_b
);

    localparam int SYNC_W = 12 + 3 * TERM_N;
    localparam int BC_W = $clog2(BLINK_CYCLES + 1);

    initial begin
        if (TERM_N < 1 || SPEED_W < 9 || BLINK_CYCLES < 1) begin
            $error("motor_driver_io_logic: unsupported parameter values");
        end
    end

    // ==========================================
    // Input synchronisation
    logic [SYNC_W-1:0] raw_vec;
    logic [SYNC_W-1:0] syn_vec;
    logic cw_s, ccw_s, style_s, hold_s, enable_s, dirsel_s, fclr_s, nclr_s;
    logic [3:0] dsel_s;
    logic [TERM_N-1:0] tl_s, lock_s, ext_s;

    assign raw_vec = {external_stop_in, panel_lock_release, torque_limit_en_in,
                      notice_clear_in, fault_clear_in, data_sel_bit3, data_sel_bit2,
                      data_sel_bit1, data_sel_bit0, direction_select, run_enable_in,
                      start_hold_in, stop_style_sel, ccw_run_cmd, cw_run_cmd};

    input_sync #(
        .W(SYNC_W),
        .RST_VAL({{TERM_N{1'b1}}, {(SYNC_W - TERM_N){1'b0}}})
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in(raw_vec),
        .sync_out(syn_vec)
    );

    assign {ext_s, lock_s, tl_s, nclr_s, fclr_s, dsel_s, dirsel_s, enable_s,
            hold_s, style_s, ccw_s, cw_s} = syn_vec;

    // ==========================================
    // Helper functions
    // All assigned terminals on; unassigned ones count as on
    function automatic logic all_on(input logic [TERM_N-1:0] val,
                                    input logic [TERM_N-1:0] asg);
        all_on = &(val | ~asg);
    endfunction

    // Selects the raw level of a terminal function
    function automatic logic func_level(input logic [2:0] sel, input logic pulse,
                                        input logic fault_n, input logic motion,
                                        input logic notice, input logic tlim,
                                        input logic reached, input logic sense);
        case (motor_io_pkg::out_func_e'(sel))
            motor_io_pkg::OUT_SPEED_PULSE: func_level = pulse;
            motor_io_pkg::OUT_FAULT: func_level = fault_n;
            motor_io_pkg::OUT_MOTION: func_level = motion;
            motor_io_pkg::OUT_NOTICE: func_level = notice;
            motor_io_pkg::OUT_TORQUE_LIMITED: func_level = tlim;
            motor_io_pkg::OUT_SPEED_REACHED: func_level = reached;
            motor_io_pkg::OUT_DIRECTION: func_level = sense;
            default: func_level = 1'b0;
        endcase
    endfunction

    // ==========================================
    // Decoded operation inputs
    logic ext_ok, run_req, instant_req, fwd_req, req_cw, fclr_block;
    logic [3:0] dsel_d;

    always_comb begin
        ext_ok = all_on(ext_s, external_stop_assigned);
        run_req = 1'b0;
        instant_req = style_s;
        fwd_req = cw_s;
        req_cw = 1'b1;
        if (three_wire_mode) begin
            run_req = hold_s & enable_s;
            // Run-enable drop is an instant stop
            instant_req = ~enable_s;
            req_cw = ~dirsel_s;
        end else begin
            // Single run command picks the direction
            run_req = cw_s ^ ccw_s;
            // Forward direction follows the positive setting
            req_cw = cw_s ? positive_is_cw : ~positive_is_cw;
            // Stop style chooses the stop kind
            instant_req = style_s;
        end
        // Mode chooses which inputs block fault clear
        fclr_block = three_wire_mode ? (hold_s & enable_s) : (cw_s | ccw_s);
        dsel_d = dsel_s & data_sel_assigned;
    end

    // ==========================================
    // Run and fault sequencing
    motor_io_pkg::run_state_e state_q, state_d;
    logic dir_cw_q, dir_cw_d;
    logic [3:0] code_q, code_d;
    logic hard_q, hard_d;
    logic fclr_q, fclr_d;
    logic fclr_rise;

    always_comb begin
        state_d = state_q;
        dir_cw_d = dir_cw_q;
        code_d = code_q;
        hard_d = hard_q;
        fclr_d = fclr_s;
        fclr_rise = fclr_s & ~fclr_q;
        // Overcurrent and memory errors latch for good
        if (overcurrent_trip || nvm_error_trip) begin
            state_d = motor_io_pkg::ST_FAULT;
            hard_d = 1'b1;
            code_d = overcurrent_trip ? `MIO_CODE_OVERCURRENT : `MIO_CODE_NVM_ERROR;
        end else if (state_q != motor_io_pkg::ST_FAULT && protect_trip) begin
            // Any protective trip enters the fault state
            state_d = motor_io_pkg::ST_FAULT;
            code_d = `MIO_CODE_PROTECT;
        end else if (state_q != motor_io_pkg::ST_FAULT && !ext_ok) begin
            state_d = motor_io_pkg::ST_FAULT;
            code_d = `MIO_CODE_EXT_STOP;
        end else begin
            case (state_q)
                motor_io_pkg::ST_IDLE: begin
                    if (run_req) begin
                        state_d = motor_io_pkg::ST_RUN;
                        dir_cw_d = req_cw;
                    end
                end
                motor_io_pkg::ST_RUN: begin
                    if (!run_req) begin
                        state_d = instant_req ? motor_io_pkg::ST_BRAKE
                                              : motor_io_pkg::ST_DECEL;
                    end else begin
                        dir_cw_d = req_cw;
                    end
                end
                motor_io_pkg::ST_DECEL, motor_io_pkg::ST_BRAKE: begin
                    if (!motor_turning) begin
                        state_d = motor_io_pkg::ST_IDLE;
                    end else if (state_q == motor_io_pkg::ST_DECEL && instant_req
                                 && !run_req) begin
                        state_d = motor_io_pkg::ST_BRAKE;
                    end
                end
                motor_io_pkg::ST_FAULT: begin
                    // Clear only with both run commands off (three-wire: hold and enable not both on) and cause gone
                    if (fclr_rise && !fclr_block && !hard_q && !protect_trip && ext_ok) begin
                        state_d = motor_io_pkg::ST_IDLE;
                        code_d = `MIO_CODE_NONE;
                    end
                end
                default: state_d = motor_io_pkg::ST_IDLE;
            endcase
        end
    end

    // Sequencing registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= motor_io_pkg::ST_IDLE;
            dir_cw_q <= 1'b1;
            code_q <= `MIO_CODE_NONE;
            hard_q <= 1'b0;
            fclr_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dir_cw_q <= dir_cw_d;
            code_q <= code_d;
            hard_q <= hard_d;
            fclr_q <= fclr_d;
        end
    end

    // ==========================================
    // Alarm indicator blink and notice flag
    logic [BC_W-1:0] blink_cnt_q, blink_cnt_d;
    logic blink_q, blink_d;
    logic notice_q, notice_d;

    always_comb begin
        blink_cnt_d = '0;
        blink_d = 1'b0;
        // Blink the alarm indicator during a fault
        if (state_q == motor_io_pkg::ST_FAULT) begin
            blink_d = blink_q;
            if (blink_cnt_q == BC_W'(BLINK_CYCLES - 1)) begin
                blink_d = ~blink_q;
            end else begin
                blink_cnt_d = blink_cnt_q + BC_W'(1);
            end
        end
        notice_d = notice_q;
        if (notice_cause) begin
            notice_d = 1'b1;
        end else if (notice_auto_clear || nclr_s) begin
            notice_d = 1'b0;
        end
    end

    // Blink and notice registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            blink_cnt_q <= '0;
            blink_q <= 1'b0;
            notice_q <= 1'b0;
        end else begin
            blink_cnt_q <= blink_cnt_d;
            blink_q <= blink_d;
            notice_q <= notice_d;
        end
    end

    // ==========================================
    // Status flags and registered outputs
    logic [SPEED_W-1:0] speed_diff;
    logic [8:0] va_eff;
    logic reached_d, tlim_d, motion_d, sense_d, tl_on_d, unlock_d, fault_n_d;
    logic reached_q, tlim_q, motion_q, sense_q, tl_on_q, unlock_q, fault_n_q;
    logic spd_pulse;

    // Speed pulse of fixed width per shaft tick that arrives outside a pulse
    speed_pulse_gen #(
        .WIDTH_CYCLES(PULSE_CYCLES)
    ) u_pulse (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .shaft_tick(shaft_tick),
        .pulse_out(spd_pulse)
    );

    always_comb begin
        speed_diff = (speed_actual > speed_target) ? (speed_actual - speed_target)
                                                   : (speed_target - speed_actual);
        // Out-of-range width is clamped into 1 to 400 r/min
        va_eff = va_width;
        if (va_width < `MIO_VA_WIDTH_MIN) begin
            va_eff = `MIO_VA_WIDTH_MIN;
        end else if (va_width > `MIO_VA_WIDTH_MAX) begin
            va_eff = `MIO_VA_WIDTH_MAX;
        end
        reached_d = (state_q == motor_io_pkg::ST_RUN)
                    && (speed_diff <= SPEED_W'(va_eff));
        tlim_d = torque_at_limit;
        motion_d = (state_q == motor_io_pkg::ST_RUN) && motor_turning;
        sense_d = motor_turning && (motor_turning_cw == positive_is_cw);
        tl_on_d = all_on(tl_s, torque_limit_assigned);
        // Panel restrictions follow the release input
        unlock_d = all_on(lock_s, panel_lock_assigned);
        // Fault output opens on any trip
        fault_n_d = (state_d != motor_io_pkg::ST_FAULT);
    end

    // Flag registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reached_q <= 1'b0;
            tlim_q <= 1'b0;
            motion_q <= 1'b0;
            sense_q <= 1'b0;
            tl_on_q <= 1'b1;
            unlock_q <= 1'b1;
            fault_n_q <= 1'b1;
        end else begin
            reached_q <= reached_d;
            tlim_q <= tlim_d;
            motion_q <= motion_d;
            sense_q <= sense_d;
            tl_on_q <= tl_on_d;
            unlock_q <= unlock_d;
            fault_n_q <= fault_n_d;
        end
    end

    // ==========================================
    // Output terminals
    logic term_a_d, term_b_d, term_a_q, term_b_q;

    always_comb begin
        // Invert unless carrying the speed pulse
        term_a_d = func_level(out_a_func, spd_pulse, fault_n_q, motion_q, notice_q,
                              tlim_q, reached_q, sense_q)
                   ^ (out_a_invert && out_a_func != 3'(motor_io_pkg::OUT_SPEED_PULSE));
        term_b_d = func_level(out_b_func, spd_pulse, fault_n_q, motion_q, notice_q,
                              tlim_q, reached_q, sense_q)
                   ^ (out_b_invert && out_b_func != 3'(motor_io_pkg::OUT_SPEED_PULSE));
    end

    // Terminal registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            term_a_q <= `MIO_INVERT_RST;
            term_b_q <= `MIO_INVERT_RST;
        end else begin
            term_a_q <= term_a_d;
            term_b_q <= term_b_d;
        end
    end

    // Command and status drive
    assign run_cmd = (state_q == motor_io_pkg::ST_RUN);
    assign dir_cw_cmd = dir_cw_q;
    assign decel_stop_cmd = (state_q == motor_io_pkg::ST_DECEL);
    // External stop brakes instead of coasting
    assign instant_stop_cmd = (state_q == motor_io_pkg::ST_BRAKE)
                              || (state_q == motor_io_pkg::ST_FAULT
                                  && code_q == `MIO_CODE_EXT_STOP);
    // Other trips let the motor coast
    assign coast_cmd = (state_q == motor_io_pkg::ST_FAULT)
                       && (code_q != `MIO_CODE_EXT_STOP);
    assign data_sel_num = dsel_d;
    assign torque_limit_on = tl_on_q;
    assign panel_unlocked = unlock_q;
    assign fault_out_n = fault_n_q;
    assign alarm_led = blink_q;
    assign alarm_code = code_q;
    assign motion_out = motion_q;
    assign notice_flag_out = notice_q;
    assign torque_limited_flag = tlim_q;
    assign speed_reached_flag = reached_q;
    assign rotation_sense_out = sense_q;
    assign speed_pulse_out = spd_pulse;
    assign output_terminal_a = term_a_q;
    assign output_terminal_b = term_b_q;

endmodule

/* rtl/motor_io_map.svh */
// Widths, reset values, codes and timing counts of the motor driver I/O logic
`ifndef MOTOR_IO_MAP_SVH
`define MOTOR_IO_MAP_SVH

// ==========================================
// Clock and timing
`define MIO_CLK_PERIOD_NS 100
`define MIO_PULSE_WIDTH_NS 200000
`define MIO_PULSE_CYCLES ((`MIO_PULSE_WIDTH_NS + `MIO_CLK_PERIOD_NS - 1) / `MIO_CLK_PERIOD_NS)
`define MIO_BLINK_HALF_MS 250
`define MIO_BLINK_CYCLES ((`MIO_BLINK_HALF_MS * 1000000) / `MIO_CLK_PERIOD_NS)

// ==========================================
// Pulses per output-shaft revolution, kept for reference by the motor loop
`define MIO_PULSES_PER_REV 30

// ==========================================
// Speed-reached detection width in r/min
`define MIO_VA_WIDTH_MIN 9'h001
`define MIO_VA_WIDTH_MAX 9'h190
`define MIO_VA_WIDTH_RST 9'h0C8

// ==========================================
// Alarm codes shown on the display
`define MIO_CODE_NONE 4'h0
`define MIO_CODE_OVERCURRENT 4'h1
`define MIO_CODE_NVM_ERROR 4'h2
`define MIO_CODE_PROTECT 4'h3
`define MIO_CODE_EXT_STOP 4'h4

// ==========================================
// Reset values of configuration defaults
`define MIO_INVERT_RST 1'h0
`define MIO_AUTO_CLEAR_RST 1'h1
`define MIO_POSITIVE_CW_RST 1'h1

`endif

/* rtl/motor_io_pkg.sv */
// Types shared by the motor driver I/O logic
package motor_io_pkg;

    // Functions that an output terminal can carry
    typedef enum logic [2:0] {
        OUT_SPEED_PULSE,
        OUT_FAULT,
        OUT_MOTION,
        OUT_NOTICE,
        OUT_TORQUE_LIMITED,
        OUT_SPEED_REACHED,
        OUT_DIRECTION
    } out_func_e;

    // Run and stop sequencing states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DECEL,
        ST_BRAKE,
        ST_FAULT
    } run_state_e;

endpackage

/* rtl/speed_pulse_gen.sv */
// Fixed-width speed pulse generator driven by shaft position ticks
`timescale 1ns/10ps
`include "motor_io_map.svh"

module speed_pulse_gen #(
    parameter int WIDTH_CYCLES = `MIO_PULSE_CYCLES
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic shaft_tick,
    output logic pulse_out
);

    localparam int CW = $clog2(WIDTH_CYCLES + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic pulse_q;
    logic pulse_d;

    initial begin
        if (WIDTH_CYCLES < 1) begin
            $error("speed_pulse_gen: pulse width must be at least one cycle");
        end
    end

    // Start a pulse on a tick; ticks inside a pulse are absorbed
    always_comb begin
        cnt_d = cnt_q;
        pulse_d = pulse_q;
        if (pulse_q) begin
            if (cnt_q == CW'(WIDTH_CYCLES - 1)) begin
                pulse_d = 1'b0;
                cnt_d = '0;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end else if (shaft_tick) begin
            pulse_d = 1'b1;
            cnt_d = '0;
        end
    end

    // Pulse registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse_out = pulse_q;

endmodule

/* testbench/motor_driver_io_logic_assertions.sv */
// Port-level checks of the motor driver I/O logic
`timescale 1ns/10ps
module motor_io_chk #(
    parameter int PULSE_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cw_run_cmd,
    input wire logic ccw_run_cmd,
    input wire logic three_wire_mode,
    input wire logic run_enable_in,
    input wire logic protect_trip,
    input wire logic shaft_tick,
    input wire logic run_cmd,
    input wire logic coast_cmd,
    input wire logic instant_stop_cmd,
    input wire logic fault_out_n,
    input wire logic [3:0] alarm_code,
    input wire logic speed_pulse_out
);
    logic [15:0] hi_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Counts the high cycles of the current speed pulse
    always_ff @(posedge mclk) begin
        hi_q <= (sys_rst || !speed_pulse_out) ? 16'h0000 : hi_q + 16'h0001;
    end
    sequence both_on_s;
        !three_wire_mode && cw_run_cmd && ccw_run_cmd;
    endsequence
    a_pulse_start: assert property (shaft_tick && !speed_pulse_out |=> speed_pulse_out)
        else $error("speed pulse did not start");
    a_pulse_width: assert property ($fell(speed_pulse_out) |-> hi_q == PULSE_CYCLES)
        else $error("speed pulse width wrong");
    a_trip_faults: assert property (protect_trip |=> !fault_out_n)
        else $error("trip did not drop fault output");
    a_fault_coasts: assert property (alarm_code == 4'h3 |-> coast_cmd && !run_cmd)
        else $error("protective trip does not coast");
    a_ext_instant: assert property (alarm_code == 4'h4 |-> instant_stop_cmd && !coast_cmd)
        else $error("external stop not instant");
    a_hard_held: assert property (alarm_code == 4'h1 |=> alarm_code == 4'h1)
        else $error("overcurrent alarm cleared");
    a_both_stop: assert property (both_on_s [*4] |-> !run_cmd)
        else $error("runs with both commands on");
    a_enable_needed: assert property (three_wire_mode && !run_enable_in [*4] |-> !run_cmd)
        else $error("runs without run enable");
endmodule
bind motor_driver_io_logic motor_io_chk #(.PULSE_CYCLES(PULSE_CYCLES)) motor_io_chk_inst (.*);

/* testbench/motor_loop_model.sv */
// Behavioural motor loop that answers the run commands
`timescale 1ns/10ps
module motor_loop_model #(
    parameter int LAG = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic run_cmd,
    input wire logic dir_cw_cmd,
    output logic motor_turning,
    output logic motor_turning_cw,
    output logic shaft_tick
);
    int lag_q;
    int phase_q;
    // ==========================================
    // Shaft runs on LAG cycles after run drops and ticks every tenth cycle
    always_ff @(posedge mclk) begin
        lag_q <= sys_rst ? 0 : run_cmd ? LAG : (lag_q > 0) ? lag_q - 1 : 0;
        phase_q <= (sys_rst || phase_q == 9) ? 0 : phase_q + 1;
        motor_turning_cw <= sys_rst ? 1'b0 : run_cmd ? dir_cw_cmd : motor_turning_cw;
    end
    assign motor_turning = lag_q > 0;
    assign shaft_tick = motor_turning && phase_q == 0;
endmodule

/* testbench/tb.sv */
// Self-checking bench of the motor driver I/O logic
`timescale 1ns/10ps
module tb;
    logic mclk = 0, sys_rst = 1, cw_run_cmd = 0, ccw_run_cmd = 0, stop_style_sel = 0;
    logic start_hold_in = 0, run_enable_in = 0, direction_select = 0, fault_clear_in = 0;
    logic data_sel_bit0 = 0, data_sel_bit1 = 0, data_sel_bit2 = 0, data_sel_bit3 = 0;
    logic notice_clear_in = 0, three_wire_mode = 0, out_a_invert = 0, out_b_invert = 0;
    logic notice_auto_clear = 1, positive_is_cw = 1, torque_at_limit = 0, notice_cause = 0;
    logic overcurrent_trip = 0, nvm_error_trip = 0, protect_trip = 0;
    logic [1:0] torque_limit_en_in = 3, panel_lock_release = 3, external_stop_in = 3;
    logic [1:0] torque_limit_assigned = 3, panel_lock_assigned = 3, external_stop_assigned = 3;
    logic [3:0] data_sel_assigned = 4'hF, data_sel_num, alarm_code;
    logic [2:0] out_a_func = 3'h2, out_b_func = 3'h0;
    logic [8:0] va_width = 9'h0C8;
    logic [11:0] speed_actual = 12'h000, speed_target = 12'h3E8;
    logic shaft_tick, motor_turning, motor_turning_cw, run_cmd, dir_cw_cmd, decel_stop_cmd;
    logic instant_stop_cmd, coast_cmd, torque_limit_on, panel_unlocked, fault_out_n, alarm_led;
    logic motion_out, notice_flag_out, torque_limited_flag, speed_reached_flag;
    logic rotation_sense_out, speed_pulse_out, output_terminal_a, output_terminal_b;
    int fails = 0, num_checks = 0;
    motor_driver_io_logic #(.PULSE_CYCLES(4), .BLINK_CYCLES(8)) motor_driver_io_logic_inst (.*);
    motor_loop_model motor_loop_model_inst (.*);
    // ==========================================
    // Clock and shared tasks
    always #50 mclk = ~mclk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Drives {cw, ccw, hold, enable, direction_select} and checks the loop commands
    task automatic op(input logic [4:0] p, input logic [3:0] e);
        @(posedge mclk) {cw_run_cmd, ccw_run_cmd, start_hold_in, run_enable_in, direction_select} <= p;
        w(4);
        chk({run_cmd, dir_cw_cmd, decel_stop_cmd, instant_stop_cmd}, e);
    endtask
    task automatic clr();
        @(posedge mclk) fault_clear_in <= 1;
        w(4);
        @(posedge mclk) fault_clear_in <= 0;
        w(2);
    endtask
    task automatic summarize();
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        w(4);
        @(posedge mclk) sys_rst <= 0;
        w(3);
        chk({fault_out_n, torque_limit_on, panel_unlocked, output_terminal_a}, 8'h0E);
        @(posedge mclk) {out_a_invert, out_b_invert} <= 2'h3;
        w(3);
        chk({output_terminal_a, output_terminal_b}, 8'h02);
        for (int n = 0; n < 16; n++) begin
            @(posedge mclk) {data_sel_bit3, data_sel_bit2, data_sel_bit1, data_sel_bit0} <= n[3:0];
            w(3);
            chk(data_sel_num, n[3:0]);
        end
        @(posedge mclk) data_sel_assigned <= 4'h3;
        w(1);
        chk(data_sel_num, 8'h03);
        op(5'b10000, 4'b1100);
        w(4);
        chk({motion_out, rotation_sense_out, output_terminal_a}, 8'h06);
        chk(speed_reached_flag, 8'h00);
        @(posedge mclk) {torque_at_limit, speed_actual} <= 13'h1384;
        w(2);
        chk(torque_limited_flag, 8'h01);
        chk(speed_reached_flag, 8'h01);
        op(5'b00000, 4'b0110);
        w(12);
        op(5'b01000, 4'b1000);
        op(5'b11000, 4'b0010);
        op(5'b00000, 4'b0010);
        w(12);
        @(posedge mclk) stop_style_sel <= 1;
        op(5'b10000, 4'b1100);
        op(5'b00000, 4'b0101);
        w(12);
        @(posedge mclk) {three_wire_mode, stop_style_sel} <= 2'h2;
        op(5'b00111, 4'b1000);
        op(5'b00011, 4'b0010);
        w(12);
        op(5'b00110, 4'b1100);
        op(5'b00100, 4'b0101);
        w(12);
        @(posedge mclk) {three_wire_mode, torque_limit_en_in, panel_lock_assigned} <= 5'h09;
        panel_lock_release <= 2'h1;
        w(4);
        chk({torque_limit_on, panel_unlocked}, 8'h01);
        @(posedge mclk) external_stop_in <= 2'h2;
        w(4);
        chk({fault_out_n, instant_stop_cmd, alarm_code}, 8'h14);
        w(8);
        chk(alarm_led, 8'h01);
        @(posedge mclk) {external_stop_in, cw_run_cmd} <= 3'h7;
        clr();
        chk(fault_out_n, 8'h00);
        @(posedge mclk) cw_run_cmd <= 0;
        clr();
        chk(fault_out_n, 8'h01);
        @(posedge mclk) protect_trip <= 1;
        @(posedge mclk) protect_trip <= 0;
        w(2);
        chk({fault_out_n, coast_cmd, alarm_code}, 8'h13);
        clr();
        @(posedge mclk) overcurrent_trip <= 1;
        @(posedge mclk) overcurrent_trip <= 0;
        clr();
        chk({fault_out_n, alarm_code}, 8'h01);
        @(posedge mclk) {notice_auto_clear, notice_cause} <= 2'h1;
        @(posedge mclk) notice_cause <= 0;
        w(3);
        chk(notice_flag_out, 8'h01);
        @(posedge mclk) notice_clear_in <= 1;
        w(4);
        chk(notice_flag_out, 8'h00);
        summarize();
    end
endmodule
